// ---- src/emsr_pkg.sv ----
// Constants, types and helpers shared by the energy meter serial reporter
package emsr_pkg;
  localparam int CLK_HZ = 250_000_000;
  // -------------------------------------------------------------------------
  // Configuration word
  // -------------------------------------------------------------------------
  localparam logic [15:0] CFG_RESET = 16'h0105;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [1:0] FMT_N81 = 2'h0;
  localparam logic [1:0] FMT_E81 = 2'h1;
  localparam logic [1:0] FMT_O81 = 2'h2;
  localparam logic [1:0] FMT_N82 = 2'h3;
  localparam logic [3:0] BAUD_1200 = 4'h3;
  localparam logic [3:0] BAUD_2400 = 4'h4;
  localparam logic [3:0] BAUD_4800 = 4'h5;
  localparam logic [3:0] BAUD_9600 = 4'h6;
  localparam logic [17:0] DIV_1200 = 18'(CLK_HZ / 1200);
  localparam logic [17:0] DIV_2400 = 18'(CLK_HZ / 2400);
  localparam logic [17:0] DIV_4800 = 18'(CLK_HZ / 4800);
  localparam logic [17:0] DIV_9600 = 18'(CLK_HZ / 9600);
  // -------------------------------------------------------------------------
  // Protocol
  // -------------------------------------------------------------------------
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] MAX_REGS = 16'h0008;
  localparam int RXB_DEPTH = 12;
  localparam logic [3:0] LEN_RD_REQ = 4'h8;
  localparam logic [3:0] LEN_WR_REQ = 4'hB;
  localparam logic [4:0] LEN_WR_RSP = 5'h08;
  localparam int GAP_BITS = 39;
  localparam logic [15:0] RA_MODEL1 = 16'h0000;
  localparam logic [15:0] RA_MODEL2 = 16'h0001;
  localparam logic [15:0] RA_VRANGE = 16'h0002;
  localparam logic [15:0] RA_IRANGE = 16'h0003;
  localparam logic [15:0] RA_CFG = 16'h0004;
  localparam logic [15:0] RA_VOLT = 16'h0048;
  localparam logic [15:0] RA_CURR = 16'h0049;
  localparam logic [15:0] RA_POWER = 16'h004A;
  localparam logic [15:0] RA_POS_HI = 16'h004B;
  localparam logic [15:0] RA_POS_LO = 16'h004C;
  localparam logic [15:0] RA_PF = 16'h004D;
  localparam logic [15:0] RA_NEG_HI = 16'h004E;
  localparam logic [15:0] RA_NEG_LO = 16'h004F;
  localparam logic [15:0] RA_DIR = 16'h0050;
  localparam logic [15:0] RA_FREQ = 16'h0051;
  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int UPDATE_MS = 1000;
  localparam int UPDATE_CYC = UPDATE_MS * (CLK_HZ / 1000);
  localparam int PULSE_NS = 80;
  localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] power;
    logic [15:0] pf;
    logic [15:0] freq;
    logic neg;
  } emsr_meas_s;

  function automatic logic [17:0] emsr_div(input logic [3:0] code);
    case (code)
      BAUD_1200: return DIV_1200;
      BAUD_2400: return DIV_2400;
      BAUD_9600: return DIV_9600;
      default: return DIV_4800;
    endcase
  endfunction

  function automatic logic [15:0] emsr_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ---- src/emsr_top.sv ----
// Energy meter serial reporter: serial responder, energy counters, pulse and LED
`timescale 1ns/100ps
// Behaviour
// - Serial link speaks Modbus RTU; this block is the addressed responder.
// - Transmit on the serial output, receive on the serial input, one channel.
// - Framing: 8N1, 8E1, 8O1 or 8N2.
// - Bit rate 1200, 2400, 4800 or 9600, same at both ends.
// - Bit rate is 4800 after reset until a configuration write.
// - Defaults: station 1, 8N1, ratio 1.
// - Reported values refresh once per 1000 ms update period.
// - Accumulated energy is a four-byte unsigned count.
// - Energy count is restored from and offered to non-volatile storage.
// - Accumulator wide enough not to wrap within ten years.
// - Indicator lit steadily, blinks with serial traffic.
// - Energy pulse output rests low, pulses per energy quantum.
// - Config high byte is station 1..255; zero is broadcast.
// - Config low byte bits 7:6 select framing 00/01/10/11.
// - Config low byte bits 3:0 select rate: 3,4,5,6.
module emsr_top #(
  parameter int UPDATE_CYC = emsr_pkg::UPDATE_CYC,
  parameter int DIV_SHIFT = 0,
  parameter logic [15:0] MODEL1_ID = 16'h0A0A, // Arbitrary value
  parameter logic [15:0] MODEL2_ID = 16'h0B0B, // Arbitrary value
  parameter logic [15:0] VRANGE = 16'h0001,
  parameter logic [15:0] IRANGE = 16'h0001
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rx_i,
  output logic tx_o,
  input wire emsr_pkg::emsr_meas_s meas_i,
  input wire logic energy_tick_i,
  input wire logic [31:0] nv_pos_i,
  input wire logic [31:0] nv_neg_i,
  output logic [31:0] nv_pos_o,
  output logic [31:0] nv_neg_o,
  output logic nv_save_o,
  output logic [15:0] cfg_o,
  output logic energy_pulse_o,
  output logic act_led_o
);
  typedef enum logic {ST_IDLE, ST_TX} emsr_st_e;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  emsr_st_e st;
  logic rx_m, rx_s;
  logic [15:0] cfg;
  logic [1:0] act_fmt;
  logic [3:0] act_baud;
  logic cfg_pend;
  logic rx_busy, rx_bad;
  logic [17:0] rx_cnt;
  logic [3:0] rx_bit, rx_n;
  logic [10:0] rx_sh;
  logic [23:0] gap_cnt;
  logic [15:0] rx_crc;
  logic [7:0] rxb [0:emsr_pkg::RXB_DEPTH-1];
  logic [7:0] rsp_addr, rsp_fc;
  logic [15:0] rsp_start;
  logic [3:0] rsp_qty;
  logic [4:0] rsp_len, tx_idx;
  logic tx_busy;
  logic [17:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [10:0] tx_sh;
  logic [15:0] tx_crc;
  logic [31:0] pos_e, neg_e, snap_pos, snap_neg;
  emsr_pkg::emsr_meas_s snap;
  logic [27:0] upd_cnt;
  logic [4:0] pulse_cnt;
  logic nv_done;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  // Bit times shrink by 2**DIV_SHIFT; zero keeps the true rates
  wire [17:0] div = emsr_pkg::emsr_div(act_baud) >> DIV_SHIFT;
  wire [3:0] nbits = (act_fmt == emsr_pkg::FMT_N81) ? 4'hA : 4'hB;
  wire par_en = act_fmt == emsr_pkg::FMT_E81 || act_fmt == emsr_pkg::FMT_O81;
  wire par_odd = act_fmt == emsr_pkg::FMT_O81;
  wire [23:0] gap_lim = 24'(div * emsr_pkg::GAP_BITS);
  wire rx_start = st == ST_IDLE && !rx_busy && !rx_s;
  wire rx_tick = rx_busy && rx_cnt == 18'h0_0000;
  wire rx_last = rx_tick && rx_bit == nbits - 4'h1;
  wire par_ok = !par_en || ((^rx_sh[9:1]) == par_odd);
  wire byte_ok = rx_s && par_ok && rx_n < 4'(emsr_pkg::RXB_DEPTH);
  wire frame_end = st == ST_IDLE && !rx_busy && rx_n != 4'h0 && gap_cnt == gap_lim;
  wire own = rxb[0] == cfg[15:8];
  wire bcast = rxb[0] == emsr_pkg::ADDR_BCAST;
  wire crc_ok = !rx_bad && rx_crc == 16'h0000;
  wire [15:0] q_start = {rxb[2], rxb[3]};
  wire [15:0] q_qty = {rxb[4], rxb[5]};
  wire [15:0] w_val = {rxb[7], rxb[8]};
  wire w_ok = w_val[15:8] != emsr_pkg::ADDR_BCAST && w_val[3:0] >= emsr_pkg::BAUD_1200 &&
              w_val[3:0] <= emsr_pkg::BAUD_9600;
  wire is_rd = rx_n == emsr_pkg::LEN_RD_REQ && rxb[1] == emsr_pkg::FC_READ &&
               q_qty != 16'h0000 && q_qty <= emsr_pkg::MAX_REGS;
  wire is_wr = rx_n == emsr_pkg::LEN_WR_REQ && rxb[1] == emsr_pkg::FC_WRITE &&
               q_start == emsr_pkg::RA_CFG && q_qty == 16'h0001 && rxb[6] == 8'h02 && w_ok;
  wire take = frame_end && crc_ok && (own || bcast) && (is_rd || is_wr);
  wire reply = take && own;
  wire tx_load = st == ST_TX && !tx_busy && tx_idx != rsp_len;
  wire tx_done = st == ST_TX && !tx_busy && tx_idx == rsp_len;
  wire [4:0] widx = tx_idx - 5'h03;
  wire [15:0] rd_addr = rsp_start + {12'h000, widx[4:1]};
  wire pbit = par_en ? ((^tx_byte) ^ par_odd) : 1'b1;

  always_comb begin
    case (rd_addr)
      emsr_pkg::RA_MODEL1: rd_word = MODEL1_ID;
      emsr_pkg::RA_MODEL2: rd_word = MODEL2_ID;
      emsr_pkg::RA_VRANGE: rd_word = VRANGE;
      emsr_pkg::RA_IRANGE: rd_word = IRANGE;
      emsr_pkg::RA_CFG: rd_word = cfg;
      emsr_pkg::RA_VOLT: rd_word = snap.volt;
      emsr_pkg::RA_CURR: rd_word = snap.curr;
      emsr_pkg::RA_POWER: rd_word = snap.power;
      emsr_pkg::RA_POS_HI: rd_word = snap_pos[31:16];
      emsr_pkg::RA_POS_LO: rd_word = snap_pos[15:0];
      emsr_pkg::RA_PF: rd_word = snap.pf;
      emsr_pkg::RA_NEG_HI: rd_word = snap_neg[31:16];
      emsr_pkg::RA_NEG_LO: rd_word = snap_neg[15:0];
      emsr_pkg::RA_DIR: rd_word = {15'h0000, snap.neg};
      emsr_pkg::RA_FREQ: rd_word = snap.freq;
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    if (tx_idx == rsp_len - 5'h02) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_idx == rsp_len - 5'h01) begin
      tx_byte = tx_crc[15:8];
    end else if (tx_idx == 5'h00) begin
      tx_byte = rsp_addr;
    end else if (tx_idx == 5'h01) begin
      tx_byte = rsp_fc;
    end else if (rsp_fc == emsr_pkg::FC_READ) begin
      tx_byte = (tx_idx == 5'h02) ? {3'h0, rsp_qty, 1'b0} :
                widx[0] ? rd_word[7:0] : rd_word[15:8];
    end else begin
      case (tx_idx)
        5'h02: tx_byte = rsp_start[15:8];
        5'h03: tx_byte = rsp_start[7:0];
        5'h04: tx_byte = 8'h00;
        default: tx_byte = 8'h01;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Input synchroniser and receiver
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else if (ce_i) begin
      rx_m <= rx_i;
      rx_s <= rx_m;
    end
  end

  // Receiver is deaf while replying: the link is half duplex
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_busy <= 1'b0;
      rx_cnt <= 18'h0_0000;
      rx_bit <= 4'h0;
      rx_sh <= 11'h000;
    end else if (ce_i) begin
      if (rx_start) begin
        rx_busy <= 1'b1;
        rx_cnt <= {1'b0, div[17:1]};
        rx_bit <= 4'h0;
      end else if (rx_tick) begin
        rx_cnt <= div - 18'h0_0001;
        rx_sh[rx_bit] <= rx_s;
        rx_bit <= rx_bit + 4'h1;
        if ((rx_bit == 4'h0 && rx_s) || rx_last) begin
          rx_busy <= 1'b0;
        end
      end else if (rx_busy) begin
        rx_cnt <= rx_cnt - 18'h0_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && rx_last && byte_ok) begin
      rxb[rx_n] <= rx_sh[8:1];
    end
  end

  // ---------------------------------------------------------------------------
  // Frame handling and transmitter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= ST_IDLE;
      cfg <= emsr_pkg::CFG_RESET;
      act_fmt <= emsr_pkg::CFG_RESET[7:6];
      act_baud <= emsr_pkg::CFG_RESET[3:0];
      cfg_pend <= 1'b0;
      rx_n <= 4'h0;
      rx_bad <= 1'b0;
      rx_crc <= emsr_pkg::CRC_INIT;
      gap_cnt <= 24'h00_0000;
      rsp_addr <= 8'h00;
      rsp_fc <= 8'h00;
      rsp_start <= 16'h0000;
      rsp_qty <= 4'h0;
      rsp_len <= 5'h00;
      tx_idx <= 5'h00;
      tx_busy <= 1'b0;
      tx_cnt <= 18'h0_0000;
      tx_bit <= 4'h0;
      tx_sh <= 11'h7FF;
      tx_crc <= emsr_pkg::CRC_INIT;
      tx_o <= 1'b1;
    end else if (ce_i) begin
      tx_o <= tx_busy ? tx_sh[0] : 1'b1;
      gap_cnt <= (rx_busy || rx_start || frame_end) ? 24'h00_0000 :
                 (gap_cnt == gap_lim) ? gap_cnt : gap_cnt + 24'h00_0001;
      if (rx_last) begin
        if (byte_ok) begin
          rx_n <= rx_n + 4'h1;
          rx_crc <= emsr_pkg::emsr_crc(rx_crc, rx_sh[8:1]);
        end else begin
          rx_bad <= 1'b1;
        end
      end
      if (frame_end) begin
        rx_n <= 4'h0;
        rx_bad <= 1'b0;
        rx_crc <= emsr_pkg::CRC_INIT;
      end
      if (take && is_wr) begin
        cfg <= w_val;
        cfg_pend <= 1'b1;
      end
      if (reply) begin
        st <= ST_TX;
        rsp_addr <= rxb[0];
        rsp_fc <= rxb[1];
        rsp_start <= q_start;
        rsp_qty <= q_qty[3:0];
        rsp_len <= is_rd ? 5'(5 + 2 * q_qty[3:0]) : emsr_pkg::LEN_WR_RSP;
        tx_idx <= 5'h00;
        tx_crc <= emsr_pkg::CRC_INIT;
      end
      if (st == ST_IDLE && cfg_pend && !take) begin
        act_fmt <= cfg[7:6];
        act_baud <= cfg[3:0];
        cfg_pend <= 1'b0;
      end
      if (tx_done) begin
        st <= ST_IDLE;
      end
      if (tx_load) begin
        tx_sh <= {1'b1, pbit, tx_byte, 1'b0};
        tx_busy <= 1'b1;
        tx_cnt <= div - 18'h0_0001;
        tx_bit <= 4'h0;
        tx_idx <= tx_idx + 5'h01;
        if (tx_idx < rsp_len - 5'h02) begin
          tx_crc <= emsr_pkg::emsr_crc(tx_crc, tx_byte);
        end
      end else if (tx_busy) begin
        if (tx_cnt != 18'h0_0000) begin
          tx_cnt <= tx_cnt - 18'h0_0001;
        end else begin
          tx_cnt <= div - 18'h0_0001;
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_bit <= tx_bit + 4'h1;
          tx_busy <= tx_bit != nbits - 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Energy, snapshot, pulse and indicator
  // ---------------------------------------------------------------------------
  // 32 bits at one quantum per tick outlasts ten years at rated load
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_done <= 1'b0;
      pos_e <= 32'h0000_0000;
      neg_e <= 32'h0000_0000;
      nv_save_o <= 1'b0;
      snap <= '0;
      snap_pos <= 32'h0000_0000;
      snap_neg <= 32'h0000_0000;
      upd_cnt <= 28'h000_0000;
      pulse_cnt <= 5'h00;
      energy_pulse_o <= 1'b0;
      act_led_o <= 1'b0;
    end else if (ce_i) begin
      nv_done <= 1'b1;
      nv_save_o <= nv_done && energy_tick_i;
      if (!nv_done) begin
        pos_e <= nv_pos_i;
        neg_e <= nv_neg_i;
      end else if (energy_tick_i && meas_i.neg) begin
        neg_e <= neg_e + 32'h0000_0001;
      end else if (energy_tick_i) begin
        pos_e <= pos_e + 32'h0000_0001;
      end
      if (upd_cnt == 28'(UPDATE_CYC - 1)) begin
        upd_cnt <= 28'h000_0000;
        snap <= meas_i;
        snap_pos <= pos_e;
        snap_neg <= neg_e;
      end else begin
        upd_cnt <= upd_cnt + 28'h000_0001;
      end
      pulse_cnt <= energy_tick_i ? 5'(emsr_pkg::PULSE_CYC) :
                   (pulse_cnt != 5'h00) ? pulse_cnt - 5'h01 : 5'h00;
      energy_pulse_o <= pulse_cnt != 5'h00;
      act_led_o <= !(rx_busy || tx_busy) || (tx_o && rx_s);
    end
  end

  assign nv_pos_o = pos_e;
  assign nv_neg_o = neg_e;
  assign cfg_o = cfg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  sequence s_load;
    tx_load;
  endsequence
  sequence s_start_bit;
    ##2 !tx_o;
  endsequence

  property p_start_bit;
    s_load |-> s_start_bit;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");
  property p_tx_idle;
    st == ST_IDLE && !tx_busy |=> tx_o;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("tx not idle high");
  property p_cfg_hold;
    st == ST_TX |=> $stable(act_baud) && $stable(act_fmt);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("setting changed mid reply");
  property p_bcast;
    frame_end && bcast |=> st == ST_IDLE;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");
  property p_pulse;
    energy_tick_i |-> ##2 energy_pulse_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("missing energy pulse");
  property p_pulse_cause;
    $rose(energy_pulse_o) |-> $past(energy_tick_i, 2);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("stray energy pulse");
  property p_count;
    nv_done && energy_tick_i && !meas_i.neg |=> pos_e == $past(pos_e) + 32'h0000_0001;
  endproperty
  a_count: assert property (p_count) else $error("energy count missed");
  property p_restore;
    $rose(nv_done) |-> pos_e == $past(nv_pos_i) && neg_e == $past(nv_neg_i);
  endproperty
  a_restore: assert property (p_restore) else $error("energy not restored");
  property p_snap;
    upd_cnt == 28'(UPDATE_CYC - 1) |=> snap == $past(meas_i) && snap_pos == $past(pos_e);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot not taken");
  property p_led;
    !rx_busy && !tx_busy |=> act_led_o;
  endproperty
  a_led: assert property (p_led) else $error("indicator dark while idle");
endmodule

// ---- tb/emsr_master.sv ----
// Modbus RTU master model on the TTL serial line, any of the four framings
`timescale 1ns/100ps
module emsr_master #(
  parameter int DIV = 52083
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  // ---------------------------------------------------------------------------
  // Line driver
  // ---------------------------------------------------------------------------
  // Idle high between characters and frames
  initial line_o = 1'b1;
  // Bit time and framing, set by the bench to follow a configuration write
  int div_cyc = DIV;
  logic [1:0] fmt = 2'b00;

  // Own CRC so that expectations never share logic with the responder
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction

  task automatic put_bit(input logic v);
    line_o = v;
    repeat (div_cyc) @(posedge clk_i);
    #1;
  endtask

  // Start bit, data LSB first, optional parity, one or two stop bits
  task automatic put_byte(input logic [7:0] b);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      put_bit(b[i]);
    end
    if (fmt == 2'b01 || fmt == 2'b10) begin
      put_bit((^b) ^ fmt[1]);
    end
    put_bit(1'b1);
    if (fmt == 2'b11) begin
      put_bit(1'b1);
    end
  endtask

  // First n bytes of f, then CRC low byte first
  task automatic send_frame(input logic [7:0] f [9], input int n);
    logic [15:0] c;
    c = 16'hffff;
    @(posedge clk_i);
    #1;
    for (int i = 0; i < n; i++) begin
      put_byte(f[i]);
      c = crc16(c, f[i]);
    end
    put_byte(c[7:0]);
    put_byte(c[15:8]);
  endtask

  task automatic send_read(input logic [7:0] addr, input logic [15:0] ra,
                           input logic [15:0] qty);
    logic [7:0] f [9];
    f = '{addr, 8'h03, ra[15:8], ra[7:0], qty[15:8], qty[7:0], 8'h00, 8'h00, 8'h00};
    send_frame(f, 6);
  endtask

  // One-register write of the configuration word
  task automatic send_write(input logic [7:0] addr, input logic [15:0] v);
    logic [7:0] f [9];
    f = '{addr, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, v[15:8], v[7:0]};
    send_frame(f, 9);
  endtask

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  // Samples mid-bit; ok is low on silence or a broken frame
  task automatic get_byte(input int limit, output logic [7:0] b, output logic ok);
    int n;
    logic st;
    logic par;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    par = 1'b0;
    while (line_i !== 1'b0 && n < limit) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= limit) begin
      return;
    end
    repeat (div_cyc / 2) @(posedge clk_i);
    #1;
    st = line_i;
    for (int i = 0; i < 8; i++) begin
      repeat (div_cyc) @(posedge clk_i);
      #1;
      b[i] = line_i;
    end
    if (fmt == 2'b01 || fmt == 2'b10) begin
      repeat (div_cyc) @(posedge clk_i);
      #1;
      par = line_i ^ (^b) ^ fmt[1];
    end
    repeat (div_cyc) @(posedge clk_i);
    #1;
    ok = (st === 1'b0) && (line_i === 1'b1) && (par === 1'b0);
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the energy meter serial reporter
`timescale 1ns/100ps
module testbench;
  // Bit times cut by 2**SHIFT keep the serial traffic inside the cycle budget
  localparam int SHIFT = 10;
  localparam int DIV = emsr_pkg::DIV_4800 >> SHIFT;
  localparam int DIV_FAST = emsr_pkg::DIV_9600 >> SHIFT;
  localparam int LIMIT = 80_000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx;
  logic tx;
  emsr_pkg::emsr_meas_s meas = '0;
  logic tick = 1'b0;
  logic [31:0] nv_pos_in = 32'h1234_5678;
  logic [31:0] nv_neg_in = 32'h0000_00ff;
  logic [31:0] nv_pos;
  logic [31:0] nv_neg;
  logic nv_save;
  logic pulse;
  logic led;
  logic [15:0] cfg;
  logic led_low = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  emsr_top #(.UPDATE_CYC(2000), .DIV_SHIFT(SHIFT)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .rx_i(rx), .tx_o(tx), .meas_i(meas),
    .energy_tick_i(tick), .nv_pos_i(nv_pos_in), .nv_neg_i(nv_neg_in), .nv_pos_o(nv_pos),
    .nv_neg_o(nv_neg), .nv_save_o(nv_save), .cfg_o(cfg), .energy_pulse_o(pulse),
    .act_led_o(led)
  );

  emsr_master #(.DIV(DIV)) master (.clk_i(clk), .line_i(tx), .line_o(rx));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Falling edge, clear of the edge that launches the indicator
  always @(negedge clk) begin
    if (rst_n && led === 1'b0) begin
      led_low = 1'b1;
    end
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Collects a reply: the first n bytes of e, then their CRC low byte first
  task automatic expect_reply(input logic [7:0] e [9], input int n);
    logic [7:0] b;
    logic ok;
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = master.crc16(c, e[i]);
    end
    for (int i = 0; i < n + 2; i++) begin
      master.get_byte(45 * master.div_cyc, b, ok);
      check(ok, 1'b1);
      check(b, i < n ? e[i] : (i == n ? c[7:0] : c[15:8]));
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    check(tx, 1'b1);
    check(pulse, 1'b0);
    check(nv_save, 1'b0);
    check(cfg, 16'h0105);
    check(cfg[15:8], 8'h01);
    check(cfg[7:6], 2'b00);
    check(cfg[3:0], 4'h5);
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(led, 1'b1);
    check(nv_pos, nv_pos_in);
    check(nv_neg, nv_neg_in);
  endtask

  // One quantum: one save strobe, one pulse of PULSE_CYC cycles, one count
  task automatic t_energy(input logic neg);
    logic [31:0] p0;
    logic [31:0] n0;
    int saves;
    int hi;
    p0 = nv_pos;
    n0 = nv_neg;
    saves = 0;
    hi = 0;
    meas.neg = neg;
    @(posedge clk);
    #1;
    tick = 1'b1;
    @(posedge clk);
    #1;
    tick = 1'b0;
    for (int i = 0; i < 30; i++) begin
      saves += (nv_save === 1'b1);
      hi += (pulse === 1'b1);
      @(posedge clk);
      #1;
    end
    check(saves, 1);
    check(hi, emsr_pkg::PULSE_CYC);
    check(pulse, 1'b0);
    check(nv_pos, neg ? p0 : p0 + 32'h0000_0001);
    check(nv_neg, neg ? n0 + 32'h0000_0001 : n0);
  endtask

  // Default station, 8N1 at 4800 bit/s answers a read of the config word
  task automatic t_read_cfg();
    logic [7:0] e [9];
    e = '{8'h01, 8'h03, 8'h02, 8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    led_low = 1'b0;
    master.send_read(8'h01, 16'h0004, 16'h0001);
    expect_reply(e, 5);
    check(led_low, 1'b1);
    repeat (2 * DIV) @(posedge clk);
    #1;
    check(led, 1'b1);
    check(tx, 1'b1);
  endtask

  // Foreign station and broadcast reads draw no reply
  task automatic t_silent();
    logic [7:0] a [2];
    logic [7:0] b;
    logic ok;
    a = '{8'h02, 8'h00};
    for (int i = 0; i < 2; i++) begin
      master.send_read(a[i], 16'h0004, 16'h0001);
      master.get_byte(45 * DIV, b, ok);
      check(ok, 1'b0);
    end
    check(cfg, 16'h0105);
  endtask

  // Own write answers at the old setting; 9600 8E1 rules the next frames
  task automatic t_write();
    logic [7:0] e [9];
    logic [7:0] b;
    logic ok;
    logic [31:0] p;
    p = nv_pos_in + 32'h0000_0001;
    e = '{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    master.send_write(8'h01, 16'h0146);
    expect_reply(e, 6);
    check(cfg, 16'h0146);
    repeat (2 * DIV) @(posedge clk);
    #1;
    master.div_cyc = DIV_FAST;
    master.fmt = 2'b01;
    e = '{8'h01, 8'h03, 8'h04, p[31:24], p[23:16], p[15:8], p[7:0], 8'h00, 8'h00};
    master.send_read(8'h01, 16'h004B, 16'h0002);
    expect_reply(e, 7);
    master.send_write(8'h00, 16'h0105);
    master.get_byte(45 * DIV_FAST, b, ok);
    check(ok, 1'b0);
    check(cfg, 16'h0105);
    master.div_cyc = DIV;
    master.fmt = 2'b00;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    t_energy(1'b0);
    t_energy(1'b1);
    t_read_cfg();
    t_silent();
    t_write();
    report_and_stop();
  end
endmodule
